// ==== aps_pkg.sv ====
// shared types and constants of the waveform playback sequencer
package aps_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int WAVE_ADDR_W   = 12;
    localparam int BLOCK_CNT_W   = 12;
    localparam int SAMPLE_W      = 16;
    localparam int ANALOG_W      = 14;
    localparam int MARKER_W      = 2;
    localparam int NUM_TRIG      = 4;
    localparam int NUM_SRC       = 8;
    localparam int SRC_SEL_W     = 3;
    localparam int BLOCK_LOG2    = 4;
    localparam int SAMPLE_CNT_W  = BLOCK_CNT_W + BLOCK_LOG2;

    // ------------------------------------------------------------------
    // field positions, mid-scale code and trigger value after reset
    // ------------------------------------------------------------------
    localparam int MARKER_LSB    = 0;
    localparam int ANALOG_LSB    = 2;
    localparam logic [SAMPLE_W-1:0] MID_SCALE_CODE = 16'h8000;
    localparam logic [NUM_TRIG-1:0] TRIG_OUT_RST   = 4'h0;

    // ------------------------------------------------------------------
    // commands
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_LAUNCH_PLAYBACK = 2'h0,
        OP_AWAIT_DONE      = 2'h1,
        OP_AWAIT_TRIGGER   = 2'h2,
        OP_DRIVE_TRIGGERS  = 2'h3
    } aps_op_t;

    typedef struct packed {
        aps_op_t                  op;
        logic [WAVE_ADDR_W-1:0]   start_addr;
        logic [BLOCK_CNT_W-1:0]   num_blocks;
        logic                     dual;
        logic [1:0]               trig_ch;
        logic [NUM_TRIG-1:0]      trig_val;
    } aps_cmd_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] ch2;
        logic [SAMPLE_W-1:0] ch1;
    } aps_pair_t;

    typedef struct packed {
        logic [ANALOG_W-1:0] analog2;
        logic [MARKER_W-1:0] marker2;
        logic [ANALOG_W-1:0] analog1;
        logic [MARKER_W-1:0] marker1;
    } aps_out_t;

    typedef enum logic [2:0] {
        ST_FETCH     = 3'h1,
        ST_WAIT_DONE = 3'h2,
        ST_WAIT_TRIG = 3'h4
    } aps_state_t;

endpackage : aps_pkg

// ==== aps_sequencer.sv ====
// waveform playback sequencer: command interpreter, playback engine, trigger handling
// How it works
// - launch only starts playback; next command immediately unless the launch went pending
// - await-done stalls until all launched playback finished
// - sample is 16 bits, two low bits markers
// - code zero negative, 65535 positive full scale
// - marker field binary: bit0 first, bit1 second
// - normalized span minus one to one is full scale
// - dual waveforms play paired samples on both outputs
// - four trigger channels with selectable source each
// - await-trigger stalls until configured edge on channel
// - playback length counted in blocks of 16 samples
// - markers leave aligned with their analog sample
// - drive-triggers sets four outputs, held until changed
`timescale 1ns/10ps
module aps_sequencer
    import aps_pkg::*;
#(
    parameter int MEM_DEPTH = 4096
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          cmd_valid_i,
    input  wire aps_cmd_t                      cmd_i,
    output logic                               cmd_ready_o,
    input  wire logic                          wave_wr_en_i,
    input  wire logic [WAVE_ADDR_W-1:0]        wave_wr_addr_i,
    input  wire aps_pair_t                     wave_wr_data_i,
    input  wire logic [NUM_SRC-1:0]            trig_src_i,
    input  wire logic [NUM_TRIG-1:0][SRC_SEL_W-1:0] trig_sel_i,
    input  wire logic [NUM_TRIG-1:0]           trig_rise_i,
    output logic [NUM_TRIG-1:0]                trig_out_o,
    output logic                               sample_valid_o,
    input  wire logic                          sample_ready_i,
    output aps_out_t                           sample_o,
    output logic                               playing_o
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (MEM_DEPTH < 16 || MEM_DEPTH > (1 << WAVE_ADDR_W)) begin : g_bad_depth
        $error("MEM_DEPTH must lie between 16 and the address space");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        aps_state_t                 state;
        logic                       cmd_ready;
        logic [NUM_TRIG-1:0]        trig_out;
        logic [NUM_SRC-1:0]         sync1;
        logic [NUM_SRC-1:0]         sync2;
        logic [NUM_SRC-1:0]         sync3;
        logic [NUM_SRC-1:0]         level;
        logic [1:0]                 wait_ch;
        logic                       active;
        logic                       act_dual;
        logic [WAVE_ADDR_W-1:0]     addr;
        logic [SAMPLE_CNT_W-1:0]    remaining;
        logic                       pend_valid;
        logic                       pend_dual;
        logic [WAVE_ADDR_W-1:0]     pend_addr;
        logic [SAMPLE_CNT_W-1:0]    pend_len;
        logic                       head_valid;
        aps_out_t                   head;
        logic                       tail_valid;
        aps_out_t                   tail;
    } aps_regs_t;

    aps_regs_t st_reg;
    aps_regs_t st_next;

    aps_pair_t wave_mem [MEM_DEPTH];

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // split one raw pair into analog code and markers; a single-channel
    // playback keeps output 2 at mid scale so it sits at zero volts
    function automatic aps_out_t split_pair(input aps_pair_t p, input logic dual);
        aps_out_t  o;
        aps_pair_t q;
        q         = p;
        if (!dual) begin
            q.ch2 = MID_SCALE_CODE;
        end
        o.analog1 = q.ch1[ANALOG_LSB +: ANALOG_W];
        o.marker1 = q.ch1[MARKER_LSB +: MARKER_W];
        o.analog2 = q.ch2[ANALOG_LSB +: ANALOG_W];
        o.marker2 = q.ch2[MARKER_LSB +: MARKER_W];
        return o;
    endfunction : split_pair

    function automatic logic [SAMPLE_CNT_W-1:0] blocks_to_samples(
        input logic [BLOCK_CNT_W-1:0] n);
        return {n, {BLOCK_LOG2{1'b0}}};
    endfunction : blocks_to_samples

    // ------------------------------------------------------------------
    // waveform memory, loaded from the side port
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (wave_wr_en_i) begin
            wave_mem[wave_wr_addr_i] <= wave_wr_data_i;
        end
    end

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    logic     accept;
    logic     push;
    logic     pop;
    logic     all_done;
    logic     edge_seen;
    logic     sel_now;
    logic     sel_old;
    aps_out_t new_word;
    logic [SRC_SEL_W-1:0] src;

    always_comb begin
        st_next   = st_reg;
        accept    = cmd_valid_i && st_reg.cmd_ready;
        pop       = st_reg.head_valid && sample_ready_i;
        // the buffer only takes a word while its second slot is free
        push      = st_reg.active && !st_reg.tail_valid;
        new_word  = split_pair(wave_mem[st_reg.addr], st_reg.act_dual);

        // trigger source synchroniser; a change counts once two stages agree
        st_next.sync1 = trig_src_i;
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (st_reg.sync2[i] == st_reg.sync3[i]) begin
                st_next.level[i] = st_reg.sync3[i];
            end
        end
        src       = trig_sel_i[st_reg.wait_ch];
        sel_now   = st_next.level[src];
        sel_old   = st_reg.level[src];
        edge_seen = trig_rise_i[st_reg.wait_ch] ? (sel_now && !sel_old)
                                                : (!sel_now && sel_old);

        // playback engine walks the active waveform, then the pending one
        if (push) begin
            st_next.addr      = st_reg.addr + WAVE_ADDR_W'(1);
            st_next.remaining = st_reg.remaining - SAMPLE_CNT_W'(1);
            if (st_reg.remaining == SAMPLE_CNT_W'(1)) begin
                // back-to-back handover keeps the sample stream seamless
                st_next.active     = st_reg.pend_valid;
                st_next.act_dual   = st_reg.pend_dual;
                st_next.addr       = st_reg.pend_addr;
                st_next.remaining  = st_reg.pend_len;
                st_next.pend_valid = 1'b0;
            end
        end

        // two-entry output buffer; head always drives the output pins
        if (pop) begin
            if (st_reg.tail_valid) begin
                st_next.head       = st_reg.tail;
                st_next.tail_valid = 1'b0;
            end else if (push) begin
                st_next.head       = new_word;
            end else begin
                st_next.head_valid = 1'b0;
            end
        end else if (push) begin
            if (st_reg.head_valid) begin
                st_next.tail       = new_word;
                st_next.tail_valid = 1'b1;
            end else begin
                st_next.head       = new_word;
                st_next.head_valid = 1'b1;
            end
        end

        all_done = !st_reg.active && !st_reg.pend_valid
                   && !st_reg.head_valid && !st_reg.tail_valid;

        unique case (st_reg.state)
            ST_FETCH: begin
                if (accept) begin
                    unique case (cmd_i.op)
                        OP_LAUNCH_PLAYBACK: begin
                            // queue the waveform; move on at once unless it went pending
                            if (cmd_i.num_blocks != '0) begin
                                if (!st_next.active) begin
                                    st_next.active    = 1'b1;
                                    st_next.act_dual  = cmd_i.dual;
                                    st_next.addr      = cmd_i.start_addr;
                                    st_next.remaining = blocks_to_samples(cmd_i.num_blocks);
                                end else begin
                                    st_next.pend_valid = 1'b1;
                                    st_next.pend_dual  = cmd_i.dual;
                                    st_next.pend_addr  = cmd_i.start_addr;
                                    st_next.pend_len   = blocks_to_samples(cmd_i.num_blocks);
                                end
                            end
                        end
                        OP_AWAIT_DONE: begin
                            st_next.state = ST_WAIT_DONE;
                        end
                        OP_AWAIT_TRIGGER: begin
                            st_next.wait_ch = cmd_i.trig_ch;
                            st_next.state   = ST_WAIT_TRIG;
                        end
                        OP_DRIVE_TRIGGERS: begin
                            st_next.trig_out = cmd_i.trig_val;
                        end
                    endcase
                end
            end
            ST_WAIT_DONE: begin
                if (all_done) begin
                    st_next.state = ST_FETCH;
                end
            end
            ST_WAIT_TRIG: begin
                // edges already through the synchroniser before the wait were absorbed in level
                if (edge_seen) begin
                    st_next.state = ST_FETCH;
                end
            end
            default: begin
                st_next.state = ST_FETCH;
            end
        endcase

        // a second launch while one is still pending must stall the fetch
        st_next.cmd_ready = (st_next.state == ST_FETCH) && !st_next.pend_valid;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg          <= '0;
            st_reg.state    <= ST_FETCH;
            st_reg.trig_out <= TRIG_OUT_RST;
        end else begin
            st_reg          <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign cmd_ready_o    = st_reg.cmd_ready;
    assign trig_out_o     = st_reg.trig_out;
    assign sample_valid_o = st_reg.head_valid;
    assign sample_o       = st_reg.head;
    assign playing_o      = st_reg.active;

endmodule : aps_sequencer

// ==== aps_sequencer_properties.sv ====
// concurrent checks on the ports of the waveform playback sequencer
`timescale 1ns/10ps
module aps_sequencer_properties
    import aps_pkg::*;
(
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 cmd_valid_i,
    input wire aps_cmd_t             cmd_i,
    input wire logic                 cmd_ready_o,
    input wire logic [NUM_SRC-1:0]   trig_src_i,
    input wire logic [NUM_TRIG-1:0]  trig_out_o,
    input wire logic                 sample_valid_o,
    input wire logic                 sample_ready_i,
    input wire aps_out_t             sample_o,
    input wire logic                 playing_o
);
    logic take;
    logic wdone_reg;
    logic wtrig_reg;
    assign take = cmd_valid_i && cmd_ready_o;
    // remembers which kind of wait is pending so a release can be judged
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdone_reg <= 1'b0;
            wtrig_reg <= 1'b0;
        end else if (take) begin
            wdone_reg <= cmd_i.op == OP_AWAIT_DONE;
            wtrig_reg <= cmd_i.op == OP_AWAIT_TRIGGER;
        end else if (cmd_ready_o) begin
            wdone_reg <= 1'b0;
            wtrig_reg <= 1'b0;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_TRIG_SET: assert property (take && cmd_i.op == OP_DRIVE_TRIGGERS |=>
        trig_out_o == $past(cmd_i.trig_val)) else $error("trigger outputs not as commanded");
    AST_TRIG_HOLD: assert property ($changed(trig_out_o) && !$past(rst_i) |->
        $past(take && cmd_i.op == OP_DRIVE_TRIGGERS)) else $error("trigger outputs moved");
    AST_DONE_STALL: assert property (take && cmd_i.op == OP_AWAIT_DONE |=> !cmd_ready_o)
        else $error("await done did not stall");
    AST_DONE_EMPTY: assert property (wdone_reg && $rose(cmd_ready_o) |->
        !sample_valid_o && !playing_o) else $error("await done released during playback");
    AST_LAUNCH_GO: assert property (take && cmd_i.op == OP_LAUNCH_PLAYBACK &&
        cmd_i.num_blocks != 12'h000 && !playing_o && !sample_valid_o
        |=> cmd_ready_o && playing_o ##1 sample_valid_o) else $error("launch did not start");
    // a source change already in the synchroniser may still release early, so
    // the stall is only judged when the sources were quiet before the command
    AST_TRIG_STALL: assert property (take && cmd_i.op == OP_AWAIT_TRIGGER &&
        trig_src_i == $past(trig_src_i) && trig_src_i == $past(trig_src_i, 2)
        |=> !cmd_ready_o [*3]) else $error("await trigger released too early");
    // a release needs one of the trigger sources, not only the selected one, to have moved five edges earlier
    AST_EDGE_CAUSE: assert property (wtrig_reg && $rose(cmd_ready_o) |->
        $past(trig_src_i, 4) != $past(trig_src_i, 5)) else $error("trigger release without edge");
    AST_WORD_HOLD: assert property (sample_valid_o && !sample_ready_i |=>
        sample_valid_o && $stable(sample_o)) else $error("stalled word not held");
    cover property (take && cmd_i.op == OP_LAUNCH_PLAYBACK);
    cover property (wdone_reg && $rose(cmd_ready_o));
    cover property (wtrig_reg && $rose(cmd_ready_o));
    cover property (sample_valid_o && !sample_ready_i);
endmodule : aps_sequencer_properties

bind aps_sequencer aps_sequencer_properties aps_sequencer_properties_i (.clk_i(clk_i),
    .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
    .trig_src_i(trig_src_i), .trig_out_o(trig_out_o), .sample_valid_o(sample_valid_o),
    .sample_ready_i(sample_ready_i), .sample_o(sample_o), .playing_o(playing_o));

// ==== aps_sink.sv ====
// behavioural analog output stage: logs accepted words, can stall every other cycle
`timescale 1ns/10ps
module aps_sink
    import aps_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    input  wire logic     stall_i,
    input  wire logic     sample_valid_i,
    input  wire aps_out_t sample_i,
    output logic          sample_ready_o
);
    aps_out_t log_q[$];
    logic     phase_reg;
    assign sample_ready_o = !stall_i || phase_reg;
    always @(posedge clk_i) begin
        phase_reg <= rst_i ? 1'b0 : !phase_reg;
        if (!rst_i && sample_valid_i && sample_ready_o) begin
            log_q.push_back(sample_i);
        end
    end
endmodule : aps_sink

// ==== tb.sv ====
// self-checking bench of the waveform playback sequencer
`timescale 1ns/10ps
module tb;
    import aps_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, wave_wr_en_i = 1'b0, stall = 1'b1;
    logic cmd_ready_o, sample_valid_o, sample_ready_i, playing_o;
    aps_cmd_t cmd_i = '0;
    logic [WAVE_ADDR_W-1:0] wave_wr_addr_i = '0;
    aps_pair_t wave_wr_data_i = '0;
    logic [NUM_SRC-1:0] trig_src_i = 8'h00;
    // channel 1 watches internal source 5 falling, channel 3 external source 2 rising
    logic [NUM_TRIG-1:0][SRC_SEL_W-1:0] trig_sel_i = {3'h2, 3'h7, 3'h5, 3'h0};
    logic [NUM_TRIG-1:0] trig_rise_i = 4'hD;
    logic [NUM_TRIG-1:0] trig_out_o;
    aps_out_t sample_o;
    int n_errors = 0, cmp_count = 0, cycles = 0;
    aps_sequencer aps_sequencer_i (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .wave_wr_en_i(wave_wr_en_i),
        .wave_wr_addr_i(wave_wr_addr_i), .wave_wr_data_i(wave_wr_data_i),
        .trig_src_i(trig_src_i), .trig_sel_i(trig_sel_i), .trig_rise_i(trig_rise_i),
        .trig_out_o(trig_out_o), .sample_valid_o(sample_valid_o),
        .sample_ready_i(sample_ready_i), .sample_o(sample_o), .playing_o(playing_o));
    aps_sink aps_sink_i (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
        .sample_valid_i(sample_valid_o), .sample_i(sample_o), .sample_ready_o(sample_ready_i));
    always #50 clk_i = ~clk_i;
    task automatic complete_run();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_ready(input int lim);
        for (int n = 0; n < lim && cmd_ready_o !== 1'b1; n++)
            @(negedge clk_i);
    endtask : wait_ready
    // offers one command and returns at the falling edge after it was taken
    task automatic send(input aps_op_t op, input logic [11:0] nb, input logic d,
                        input logic [1:0] ch, input logic [3:0] tv);
        @(negedge clk_i);
        cmd_valid_i = 1'b1;
        cmd_i = '{op, 12'h000, nb, d, ch, tv};
        wait_ready(300);
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
    endtask : send
    task automatic t_drive();
        logic [3:0] vals [3] = '{4'h3, 4'hA, 4'h5};
        foreach (vals[i]) begin
            send(OP_DRIVE_TRIGGERS, 12'h000, 1'b0, 2'h0, vals[i]);
            chk("trig_out_o", 32'(vals[i]), 32'(trig_out_o));
        end
    endtask : t_drive
    task automatic t_play();
        logic [15:0] c1;
        aps_sink_i.log_q.delete();
        send(OP_LAUNCH_PLAYBACK, 12'h000, 1'b1, 2'h0, 4'h0);
        chk("playing after empty launch", 32'h0, 32'(playing_o));
        for (int k = 0; k < 16; k++) begin
            @(negedge clk_i);
            c1 = 16'h1111 * k[3:0];
            wave_wr_en_i = 1'b1;
            wave_wr_addr_i = 12'(k);
            wave_wr_data_i = '{~c1, c1};
        end
        @(negedge clk_i);
        wave_wr_en_i = 1'b0;
        send(OP_LAUNCH_PLAYBACK, 12'h001, 1'b1, 2'h0, 4'h0);
        chk("ready after launch", 32'h1, 32'(cmd_ready_o));
        send(OP_LAUNCH_PLAYBACK, 12'h001, 1'b0, 2'h0, 4'h0);
        send(OP_AWAIT_DONE, 12'h000, 1'b0, 2'h0, 4'h0);
        chk("ready in wait", 32'h0, 32'(cmd_ready_o));
        wait_ready(300);
        chk("words at release", 32'h20, 32'(aps_sink_i.log_q.size()));
        for (int k = 0; k < 32; k++) begin
            c1 = 16'h1111 * k[3:0];
            chk("sample_o", k < 16 ? {~c1, c1} : {16'h8000, c1},
                aps_sink_i.log_q[k]);
        end
        chk("trig_out_o held", 32'h5, 32'(trig_out_o));
    endtask : t_play
    // edges before the command and of the wrong sense must not release the wait
    task automatic t_trig(input logic [1:0] ch, input int src, input logic rise);
        trig_src_i[src] = !rise;
        repeat (8) @(negedge clk_i);
        trig_src_i[src] = rise;
        repeat (8) @(negedge clk_i);
        send(OP_AWAIT_TRIGGER, 12'h000, 1'b0, ch, 4'h0);
        chk("ready in trigger wait", 32'h0, 32'(cmd_ready_o));
        trig_src_i = ~trig_src_i;
        repeat (10) @(negedge clk_i);
        chk("ready after wrong edge", 32'h0, 32'(cmd_ready_o));
        trig_src_i[src] = rise;
        wait_ready(8);
        chk("ready after edge", 32'h1, 32'(cmd_ready_o));
    endtask : t_trig
    initial begin
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        t_drive();
        t_play();
        t_trig(2'h1, 5, 1'b0);
        t_trig(2'h3, 2, 1'b1);
        complete_run();
    end
endmodule : tb
